// ==== common/dcsi_map.svh ====
`ifndef DCSI_MAP_SVH
`define DCSI_MAP_SVH

// Sizes
`define DCSI_N_IN 8
`define DCSI_N_PAIR 4

// Register byte offsets
`define DCSI_OFS_XS_EN 8'h00
`define DCSI_OFS_PULSE_SEL 8'h04
`define DCSI_OFS_PAIR_CFG 8'h08
`define DCSI_OFS_START_EN 8'h0C
`define DCSI_OFS_STATE 8'h10
`define DCSI_OFS_IRQ_STAT 8'h14
`define DCSI_OFS_IRQ_MASK 8'h18

// Field positions
`define DCSI_PAIR_EN_LSB 0
`define DCSI_PAIR_AV_LSB 4
`define DCSI_PAIR_TMO_LSB 8
`define DCSI_ST_DIN_LSB 0
`define DCSI_ST_FAULT_LSB 8
`define DCSI_ST_ALARM_BIT 16
`define DCSI_ST_PAIR_LSB 17
`define DCSI_IRQ_ALARM_BIT 0
`define DCSI_IRQ_MISM_BIT 1
`define DCSI_IRQ_CHG_BIT 2

// Reset values
`define DCSI_RST_CFG8 8'h00
`define DCSI_RST_PAIR 12'h000
`define DCSI_RST_IRQ 3'h0

// Inputs that take part in the switch-to-low test
`define DCSI_LOW_TEST_MASK 8'h0F

// Signature patterns of the two pulse outputs
`define DCSI_SIG_A 8'hCA
`define DCSI_SIG_B 8'h35

// Timing
`define DCSI_CLK_HZ 20000000
`define DCSI_TEST_PERIOD_US 100
`define DCSI_TEST_PERIOD_CYC (`DCSI_TEST_PERIOD_US * (`DCSI_CLK_HZ / 1000000))
`define DCSI_TEST_LEN_NS 200
`define DCSI_TEST_LEN_CYC ((`DCSI_TEST_LEN_NS * (`DCSI_CLK_HZ / 1000000)) / 1000)
`define DCSI_STEP_NS 1000
`define DCSI_STEP_CYC ((`DCSI_STEP_NS * (`DCSI_CLK_HZ / 1000000)) / 1000)
`define DCSI_TMO_MS 500
`define DCSI_TMO_CYC (`DCSI_TMO_MS * (`DCSI_CLK_HZ / 1000))

`endif

// ==== common/dcsi_pkg.sv ====
`default_nettype none

package dcsi_pkg;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } dcsi_apb_req_s;

    // APB answer of the slave
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dcsi_apb_rsp_s;

    // Dynamic test sequencer states
    typedef enum logic [2:0] {
        TST_IDLE = 3'b001,
        TST_THR = 3'b010,
        TST_LOW = 3'b100
    } dcsi_tst_e;

endpackage : dcsi_pkg

`default_nettype wire

// ==== design/dcsi_pulse_gen.sv ====
`include "dcsi_map.svh"
`default_nettype none

module dcsi_pulse_gen (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Signature pulses and their step and frame timing
    output var logic [1:0] pulse_o,
    output var logic step_o,
    output var logic frame_o
);
    import dcsi_pkg::*;

    localparam logic [1:0][7:0] PAT = {`DCSI_SIG_B, `DCSI_SIG_A};
    localparam logic [4:0] STEP_M1 = 5'(`DCSI_STEP_CYC - 1);

    logic [4:0] cnt_q;
    logic [2:0] idx_q;
    logic [2:0] idx_d;

    assign idx_d = idx_q + 3'h1;

    // Step timer and bit index
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_q <= 5'h00;
            idx_q <= 3'h0;
            step_o <= 1'b0;
            frame_o <= 1'b0;
        end
        else
        begin
            step_o <= (cnt_q == STEP_M1);
            frame_o <= (cnt_q == STEP_M1) && (idx_q == 3'h7);
            if (cnt_q == STEP_M1)
            begin
                cnt_q <= 5'h00;
                idx_q <= idx_d;
            end
            else
            begin
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end

    // One shifter per output, each with its own pattern
    for (genvar j = 0; j < 2; j++)
    begin : g_pulse
        always_ff @(posedge clk_sys_i or negedge nrst_i)
        begin
            if (!nrst_i)
                pulse_o[j] <= PAT[j][0];
            else if (cnt_q == STEP_M1)
                pulse_o[j] <= PAT[j][idx_d];
        end
    end

    pulse_distinct_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        pulse_o[0] != pulse_o[1]) else $error("pulse outputs carry the same level");

endmodule // dcsi_pulse_gen

`default_nettype wire

// ==== design/dcsi_sig_check.sv ====
`include "dcsi_map.svh"
`default_nettype none

module dcsi_sig_check (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Levels and settings
    input wire logic [`DCSI_N_IN-1:0] lvl_i,
    input wire logic [`DCSI_N_IN-1:0] en_i,
    input wire logic [`DCSI_N_IN-1:0] sel_i,
    // Pulse timing
    input wire logic [1:0] pulse_i,
    input wire logic step_i,
    input wire logic frame_i,
    // Verdict
    output var logic [`DCSI_N_IN-1:0] ok_o,
    output var logic [`DCSI_N_IN-1:0] fault_o
);
    import dcsi_pkg::*;

    logic [1:0] exp_q;
    logic [`DCSI_N_IN-1:0] hi_q;
    logic [`DCSI_N_IN-1:0] bad_q;

    // Pulse level valid during the step that just ended
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            exp_q <= 2'h0;
        else
            exp_q <= pulse_i;
    end

    // Per input signature compare over one frame
    for (genvar i = 0; i < `DCSI_N_IN; i++)
    begin : g_chk
        logic mis;
        assign mis = lvl_i[i] ^ exp_q[sel_i[i]];
        always_ff @(posedge clk_sys_i or negedge nrst_i)
        begin
            if (!nrst_i)
            begin
                hi_q[i] <= 1'b0;
                bad_q[i] <= 1'b0;
                ok_o[i] <= 1'b0;
                fault_o[i] <= 1'b0;
            end
            else if (step_i && frame_i)
            begin
                hi_q[i] <= 1'b0;
                bad_q[i] <= 1'b0;
                ok_o[i] <= en_i[i] && (hi_q[i] || lvl_i[i]) && !(bad_q[i] || mis);
                fault_o[i] <= fault_o[i] || (en_i[i] && (hi_q[i] || lvl_i[i]) && (bad_q[i] || mis));
            end
            else if (step_i)
            begin
                hi_q[i] <= hi_q[i] || lvl_i[i];
                bad_q[i] <= bad_q[i] || mis;
            end
        end
    end

    sig_fault_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (step_i && frame_i && en_i[0] && (hi_q[0] || lvl_i[0]) && bad_q[0]) |=> fault_o[0] && !ok_o[0])
        else $error("wrong signature not flagged");

endmodule // dcsi_sig_check

`default_nettype wire

// ==== design/dcsi_top.sv ====
// Contract
// - Input High only when both channels High; pulse-fed inputs need a good frame verdict and agreeing channels
// - Core tests always on, others enabled
// - Cyclic high-threshold test, alarm on failure
// - Cyclic switch-to-low test, inputs 5-8 excluded
// - Pulse outputs carry distinct signatures
// - Enabled inputs must carry assigned signature
// - Per-input pulse choice exposes neighbour shorts
// - Multi-contact sensor High needs all contacts
// - Two NC contacts: High when both closed
// - NO plus NC: NO actuated, NC not
// - Invalid contact combination over 0.5 s alarms
`include "dcsi_map.svh"
`default_nettype none

module dcsi_top #(
    parameter int unsigned TMO_CYC = `DCSI_TMO_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // APB slave
    input wire dcsi_pkg::dcsi_apb_req_s apb_i,
    output var dcsi_pkg::dcsi_apb_rsp_s apb_o,
    // Redundant input channels and threshold probe
    input wire logic [`DCSI_N_IN-1:0] ch_a_i,
    input wire logic [`DCSI_N_IN-1:0] ch_b_i,
    input wire logic [`DCSI_N_IN-1:0] thr_ok_i,
    // Front end test strobes and pulses
    output var logic thr_test_o,
    output var logic low_test_o,
    output var logic [1:0] pulse_o,
    // Evaluated results
    output var logic [`DCSI_N_IN-1:0] din_o,
    output var logic [`DCSI_N_PAIR-1:0] pair_o,
    output var logic alarm_o,
    output var logic irq_o
);
    import dcsi_pkg::*;

    localparam int N = `DCSI_N_IN;
    localparam logic [11:0] PERIOD_M1 = 12'(`DCSI_TEST_PERIOD_CYC - 1);
    localparam logic [11:0] LEN_M1 = 12'(`DCSI_TEST_LEN_CYC - 1);
    localparam logic [23:0] TMO_LIM = 24'(TMO_CYC);

    // Address decode shared by read and write
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == `DCSI_OFS_XS_EN) || (a == `DCSI_OFS_PULSE_SEL) || (a == `DCSI_OFS_PAIR_CFG) ||
                   (a == `DCSI_OFS_START_EN) || (a == `DCSI_OFS_STATE) || (a == `DCSI_OFS_IRQ_STAT) ||
                   (a == `DCSI_OFS_IRQ_MASK);
    endfunction

    logic [N-1:0] xs_en_q;
    logic [N-1:0] psel_q;
    logic [11:0] pair_cfg_q;
    logic start_en_q;
    logic [2:0] irq_st_q;
    logic [2:0] irq_st_d;
    logic [2:0] irq_msk_q;
    logic [2:0] irq_ev;
    logic [31:0] rdata_d;
    logic acc;
    logic wr_en;
    dcsi_tst_e st_q;
    dcsi_tst_e st_d;
    logic [11:0] tcnt_q;
    logic last;
    logic [N-1:0] thr_fail;
    logic [N-1:0] low_fail;
    logic [N-1:0] both_q;
    logic mism_ev;
    logic [N-1:0] sig_ok;
    logic [N-1:0] sig_fault;
    logic step;
    logic frame;
    logic [N-1:0] val;
    logic [N-1:0] start_seen_q;
    logic primed_q;
    logic [N-1:0] tmo_fault;
    logic [N-1:0] new_fault;
    logic [N-1:0] fault_q;
    logic [N-1:0] din_d;
    logic [`DCSI_N_PAIR-1:0] pair_d;

    // APB handshake: one wait state, then answer
    assign acc = apb_i.psel && apb_i.penable && !apb_o.pready;
    assign wr_en = apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite && addr_hit(apb_i.paddr);

    // Read data mux
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (apb_i.paddr)
            `DCSI_OFS_XS_EN: rdata_d[N-1:0] = xs_en_q;
            `DCSI_OFS_PULSE_SEL: rdata_d[N-1:0] = psel_q;
            `DCSI_OFS_PAIR_CFG: rdata_d[11:0] = pair_cfg_q;
            `DCSI_OFS_START_EN: rdata_d[0] = start_en_q;
            `DCSI_OFS_STATE:
            begin
                rdata_d[`DCSI_ST_DIN_LSB +: N] = din_o;
                rdata_d[`DCSI_ST_FAULT_LSB +: N] = fault_q;
                rdata_d[`DCSI_ST_ALARM_BIT] = alarm_o;
                rdata_d[`DCSI_ST_PAIR_LSB +: `DCSI_N_PAIR] = pair_o;
            end
            `DCSI_OFS_IRQ_STAT: rdata_d[2:0] = irq_st_q;
            `DCSI_OFS_IRQ_MASK: rdata_d[2:0] = irq_msk_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // APB answer flops
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            apb_o <= '0;
        else
        begin
            apb_o.pready <= acc;
            apb_o.pslverr <= acc && !addr_hit(apb_i.paddr);
            apb_o.prdata <= (acc && !apb_i.pwrite) ? rdata_d : 32'h0000_0000;
        end
    end

    // Configuration registers; optional tests off after reset
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            xs_en_q <= `DCSI_RST_CFG8;
            psel_q <= `DCSI_RST_CFG8;
            pair_cfg_q <= `DCSI_RST_PAIR;
            start_en_q <= 1'b0;
            irq_msk_q <= `DCSI_RST_IRQ;
        end
        else if (wr_en)
        begin
            case (apb_i.paddr)
                `DCSI_OFS_XS_EN: xs_en_q <= apb_i.pwdata[N-1:0];
                `DCSI_OFS_PULSE_SEL: psel_q <= apb_i.pwdata[N-1:0];
                `DCSI_OFS_PAIR_CFG: pair_cfg_q <= apb_i.pwdata[11:0];
                `DCSI_OFS_START_EN: start_en_q <= apb_i.pwdata[0];
                `DCSI_OFS_IRQ_MASK: irq_msk_q <= apb_i.pwdata[2:0];
                default: ;
            endcase
        end
    end

    // Test sequencer next state, always running
    assign last = (tcnt_q == LEN_M1);
    always_comb
    begin
        case (st_q)
            TST_IDLE: st_d = (tcnt_q == PERIOD_M1) ? TST_THR : TST_IDLE;
            TST_THR: st_d = last ? TST_LOW : TST_THR;
            TST_LOW: st_d = last ? TST_IDLE : TST_LOW;
            default: st_d = TST_IDLE;
        endcase
    end

    // Sequencer state, counter and strobes
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_q <= TST_IDLE;
            tcnt_q <= 12'h000;
            thr_test_o <= 1'b0;
            low_test_o <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            tcnt_q <= (st_d != st_q) ? 12'h000 : tcnt_q + 12'h001;
            thr_test_o <= (st_d == TST_THR);
            low_test_o <= (st_d == TST_LOW);
        end
    end

    // Test verdicts at the end of each window
    assign thr_fail = (st_q == TST_THR && last) ? ~thr_ok_i : '0;
    assign low_fail = (st_q == TST_LOW && last) ? ((ch_a_i | ch_b_i) & `DCSI_LOW_TEST_MASK) : '0;

    // Cross comparison, frozen while a test forces the front end
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            both_q <= '0;
        else if (st_q == TST_IDLE)
            both_q <= ch_a_i & ch_b_i;
    end
    assign mism_ev = (st_q == TST_IDLE) && (ch_a_i != ch_b_i);

    dcsi_pulse_gen u_pulse (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .pulse_o(pulse_o),
        .step_o(step),
        .frame_o(frame)
    );

    dcsi_sig_check u_sig (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .lvl_i(both_q),
        .en_i(xs_en_q),
        .sel_i(psel_q),
        .pulse_i(pulse_o),
        .step_i(step),
        .frame_i(frame),
        .ok_o(sig_ok),
        .fault_o(sig_fault)
    );

    // Pulse-fed inputs report the frame verdict, not the pulse; a channel mismatch still forces Low
    assign val = (both_q & ~xs_en_q) | (sig_ok & xs_en_q & ~(ch_a_i ^ ch_b_i));

    // Start test: input must be seen Low once after power-up
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            primed_q <= 1'b0;
            start_seen_q <= '0;
        end
        else
        begin
            // First cycle skipped: its Low is only the pipeline's reset value
            primed_q <= 1'b1;
            start_seen_q <= start_seen_q | (primed_q ? ~val : '0);
        end
    end

    // Sticky faults and module alarm, cleared by reset only
    assign new_fault = thr_fail | low_fail | sig_fault | tmo_fault;
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            fault_q <= '0;
            alarm_o <= 1'b0;
        end
        else
        begin
            fault_q <= fault_q | new_fault;
            alarm_o <= alarm_o || (|new_fault);
        end
    end

    // Reported inputs
    assign din_d = val & (start_en_q ? start_seen_q : '1) & ~fault_q & ~new_fault;
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            din_o <= '0;
        else
            din_o <= din_d;
    end

    // Two-contact elements on input pairs
    for (genvar k = 0; k < `DCSI_N_PAIR; k++)
    begin : g_pair
        logic ca;
        logic cb;
        logic en;
        logic av;
        logic valid;
        logic [23:0] cnt_q;
        assign ca = din_o[2*k];
        assign cb = din_o[2*k+1];
        assign en = pair_cfg_q[`DCSI_PAIR_EN_LSB + k];
        assign av = pair_cfg_q[`DCSI_PAIR_AV_LSB + k];
        assign valid = av ? (ca ^ cb) : (ca == cb);
        assign pair_d[k] = en && (av ? (ca && !cb) : (ca && cb));
        assign tmo_fault[2*k+1:2*k] = {2{cnt_q == TMO_LIM}};
        always_ff @(posedge clk_sys_i or negedge nrst_i)
        begin
            if (!nrst_i)
                cnt_q <= 24'h000000;
            else if (en && pair_cfg_q[`DCSI_PAIR_TMO_LSB + k] && !valid && cnt_q != TMO_LIM)
                cnt_q <= cnt_q + 24'h000001;
            else
                cnt_q <= 24'h000000;
        end
    end

    // Pair results
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pair_o <= '0;
        else
            pair_o <= pair_d;
    end

    // Interrupt status: set wins over write-one-clear
    assign irq_ev = {din_d != din_o, mism_ev, (|new_fault) && !alarm_o};
    assign irq_st_d = (irq_st_q & ~((wr_en && apb_i.paddr == `DCSI_OFS_IRQ_STAT) ? apb_i.pwdata[2:0] : 3'h0))
                      | irq_ev;
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            irq_st_q <= `DCSI_RST_IRQ;
            irq_o <= 1'b0;
        end
        else
        begin
            irq_st_q <= irq_st_d;
            irq_o <= |(irq_st_d & irq_msk_q);
        end
    end

    cross_cmp_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (din_o & ~$past(both_q | (xs_en_q & ~(ch_a_i ^ ch_b_i)))) == '0)
        else $error("input High without both channels");
    thr_alarm_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (st_q == TST_THR && last && !(&thr_ok_i)) |=> alarm_o && (fault_q & ~$past(thr_ok_i)) == $past(~thr_ok_i))
        else $error("threshold failure not alarmed");
    low_alarm_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (st_q == TST_LOW && last && ((ch_a_i | ch_b_i) & `DCSI_LOW_TEST_MASK) != '0) |=> alarm_o)
        else $error("switch-to-low failure not alarmed");
    test_cycle_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(thr_test_o) |-> thr_test_o [*4] ##1 (low_test_o && !thr_test_o))
        else $error("dynamic test sequence broken");
    alarm_hold_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        alarm_o |=> alarm_o && (din_o & fault_q) == '0) else $error("alarm or fault released");
    pair_nc_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (pair_o[0] && !pair_cfg_q[`DCSI_PAIR_AV_LSB]) |-> $past(din_o[0] && din_o[1]))
        else $error("NC pair High without both closed");
    pair_nonc_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (pair_o[0] && pair_cfg_q[`DCSI_PAIR_AV_LSB]) |-> $past(din_o[0] && !din_o[1]))
        else $error("NO/NC pair High in wrong combination");
    tmo_alarm_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (tmo_fault[0]) |=> alarm_o && fault_q[1:0] == 2'h3) else $error("contact time-out not alarmed");
    start_gate_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (start_en_q && !start_seen_q[0]) |=> !din_o[0]) else $error("start test bypassed");

endmodule // dcsi_top

`default_nettype wire

// ==== bench/dcsi_sensor_model.sv ====
`default_nettype none

module dcsi_sensor_model (
    // Pulse supply and test strobe from the block
    input wire logic [1:0] pulse_i,
    input wire logic low_test_i,
    // Contact states and wiring
    input wire logic [7:0] contact_i,
    input wire logic [7:0] feed_i,
    input wire logic [7:0] sel_i,
    // Injected faults
    input wire logic [7:0] short_i,
    input wire logic [7:0] stuck_i,
    input wire logic [7:0] mis_b_i,
    input wire logic [7:0] thr_bad_i,
    // Levels towards the block
    output var logic [7:0] ch_a_o,
    output var logic [7:0] ch_b_o,
    output var logic [7:0] thr_ok_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] lvl;
    // Fed contacts carry their pulse, a short swaps the source
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            lvl[i] = contact_i[i] & (!feed_i[i] | pulse_i[sel_i[i] ^ short_i[i]]);
        end
    end
    // Front end pulls inputs low in the window unless stuck
    assign ch_a_o = low_test_i ? (lvl & stuck_i) : lvl;
    assign ch_b_o = ch_a_o & ~mis_b_i;
    assign thr_ok_o = ~thr_bad_i;
endmodule // dcsi_sensor_model

`default_nettype wire

// ==== bench/dcsi_top_tb.sv ====
`include "dcsi_map.svh"
`default_nettype none

module dcsi_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dcsi_pkg::*;
    localparam int TMO = 50;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    dcsi_apb_req_s apb_i = '0;
    dcsi_apb_rsp_s apb_o;
    logic [7:0] ch_a, ch_b, thr_ok, din;
    logic [3:0] pair;
    logic [1:0] pulse;
    logic thr_test, low_test, alarm, irq;
    logic [7:0] contact = 8'hFF, feed = '0, sel = '0, short_m = '0, stuck = '0, mis_b = '0, thr_bad = '0;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;

    // Clock and run limit
    always #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            final_report();
        end
    end

    dcsi_top #(.TMO_CYC(TMO)) i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .apb_i(apb_i), .apb_o(apb_o),
        .ch_a_i(ch_a), .ch_b_i(ch_b), .thr_ok_i(thr_ok), .thr_test_o(thr_test), .low_test_o(low_test),
        .pulse_o(pulse), .din_o(din), .pair_o(pair), .alarm_o(alarm), .irq_o(irq));
    dcsi_sensor_model i_sensor (.pulse_i(pulse), .low_test_i(low_test), .contact_i(contact), .feed_i(feed),
        .sel_i(sel), .short_i(short_m), .stuck_i(stuck), .mis_b_i(mis_b), .thr_bad_i(thr_bad),
        .ch_a_o(ch_a), .ch_b_o(ch_b), .thr_ok_o(thr_ok));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // One APB transfer, held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge clk_sys_i);
        apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge clk_sys_i);
        apb_i.penable <= 1'b1;
        do
        begin
            @(posedge clk_sys_i);
        end while (apb_o.pready !== 1'b1);
        rd = apb_o.prdata;
        er = apb_o.pslverr;
        apb_i <= '0;
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(rd, exp);
        chk(er, 1'b0);
    endtask

    // Reset with a healthy sensor set
    task automatic do_reset();
        nrst_i <= 1'b0;
        {feed, sel, short_m, stuck, mis_b, thr_bad} <= '0;
        contact <= 8'hFF;
        cycles(2);
        chk(pulse, 2'b10);
        chk(alarm, 1'b0);
        nrst_i <= 1'b1;
        cycles(20);
    endtask

    task automatic t_regs();
        logic [7:0] ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h18};
        foreach (ofs[i])
            rd_chk(ofs[i], 32'h0);
        // Inputs went High after reset: the input-changed event is pending
        rd_chk(`DCSI_OFS_IRQ_STAT, 32'h0000_0004);
        apb(1'b1, `DCSI_OFS_PULSE_SEL, 32'hFFFF_FFFF);
        rd_chk(`DCSI_OFS_PULSE_SEL, 32'h0000_00FF);
        apb(1'b1, `DCSI_OFS_PULSE_SEL, 32'h0);
        apb(1'b1, `DCSI_OFS_STATE, 32'h0);
        rd_chk(`DCSI_OFS_STATE, 32'h0000_00FF);
        apb(1'b0, 8'h1C, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_cross();
        chk(din, 8'hFF);
        apb(1'b1, `DCSI_OFS_IRQ_STAT, 32'h7);
        mis_b <= 8'h04;
        cycles(20);
        chk(din, 8'hFB);
        rd_chk(`DCSI_OFS_STATE, 32'h0000_00FB);
        apb(1'b0, `DCSI_OFS_IRQ_STAT, 32'h0);
        chk(rd[1], 1'b1);
        chk(irq, 1'b0);
        apb(1'b1, `DCSI_OFS_IRQ_MASK, 32'h2);
        cycles(3);
        chk(irq, 1'b1);
        mis_b <= 8'h00;
        cycles(20);
        chk(din, 8'hFF);
        apb(1'b1, `DCSI_OFS_IRQ_STAT, 32'h7);
        cycles(3);
        chk({alarm, irq}, 2'b00);
        apb(1'b1, `DCSI_OFS_IRQ_MASK, 32'h0);
        $display("test cross done");
    endtask

    task automatic t_pairs();
        apb(1'b1, `DCSI_OFS_PAIR_CFG, 32'h013);
        for (int v = 0; v < 16; v++)
        begin
            contact <= {4'hF, 4'(v)};
            cycles(20);
            chk(pair[1:0], {v[2] & v[3], v[0] & ~v[1]});
        end
        contact <= 8'hFE;
        cycles(100);
        chk(alarm, 1'b0);
        $display("test pairs done");
    endtask

    task automatic t_tmo();
        do_reset();
        apb(1'b1, `DCSI_OFS_PAIR_CFG, 32'h101);
        contact <= 8'hFE;
        cycles(40);
        chk(alarm, 1'b0);
        cycles(30);
        chk(alarm, 1'b1);
        chk(din, 8'hFC);
        contact <= 8'hFF;
        cycles(40);
        chk({alarm, din}, {1'b1, 8'hFC});
        apb(1'b0, `DCSI_OFS_IRQ_STAT, 32'h0);
        chk(rd[0], 1'b1);
        $display("test timeout done");
    endtask

    task automatic t_dyn();
        do_reset();
        thr_bad <= 8'h02;
        cycles(2020);
        chk({alarm, din}, {1'b1, 8'hFD});
        do_reset();
        stuck <= 8'h20;
        cycles(2020);
        chk({alarm, din}, {1'b0, 8'hFF});
        stuck <= 8'h24;
        cycles(2020);
        chk({alarm, din}, {1'b1, 8'hFB});
        $display("test dynamic done");
    endtask

    task automatic t_xs();
        do_reset();
        feed <= 8'h03;
        sel <= 8'h02;
        apb(1'b1, `DCSI_OFS_PULSE_SEL, 32'h02);
        // Let one frame end with the check off, so rewiring leaves no stale mismatch
        cycles(180);
        apb(1'b1, `DCSI_OFS_XS_EN, 32'h03);
        for (int k = 0; k < 16; k++)
        begin
            cycles(20);
            chk(pulse[0] ^ pulse[1], 1'b1);
        end
        chk({alarm, din}, {1'b0, 8'hFF});
        short_m <= 8'h01;
        cycles(400);
        chk({alarm, din}, {1'b1, 8'hFE});
        $display("test cross-short done");
    endtask

    task automatic t_start();
        do_reset();
        apb(1'b1, `DCSI_OFS_START_EN, 32'h1);
        cycles(10);
        chk(din, 8'h00);
        contact <= 8'h00;
        cycles(12);
        contact <= 8'hFF;
        cycles(12);
        chk(din, 8'hFF);
        $display("test start done");
    endtask

    initial
    begin
        do_reset();
        t_regs();
        t_cross();
        t_pairs();
        t_tmo();
        t_dyn();
        t_xs();
        t_start();
        final_report();
    end
endmodule // dcsi_top_tb

`default_nettype wire
